// *** rtl/ips_map.vh ***
// Purpose: register map and field layout for the interrupt priority block
// Assumes: 32-bit axi4-lite access, one aligned word per register
// Notes: definitions only
`ifndef IPS_MAP_VH
`define IPS_MAP_VH

// ************************************************
// register byte addresses
// ************************************************
`define IPS_ADDR_PRIO2 4'h0
`define IPS_ADDR_RCTL 4'h4
`define IPS_ADDR_W 4

// ************************************************
// priority register fields
// ************************************************
`define IPS_PRIO2_MASK 8'h1f
`define IPS_PRIO2_RESET 5'h1f
`define IPS_BIT_NVM 4
`define IPS_BIT_BCL 3
`define IPS_BIT_LVD 2
`define IPS_BIT_TMR3 1
`define IPS_BIT_CCP2 0
`define IPS_NSRC 5

// ************************************************
// reset-control register fields
// ************************************************
`define IPS_BIT_PEN 7
`define IPS_BIT_SWR 4
`define IPS_BIT_WDT 3
`define IPS_BIT_PWD 2
`define IPS_BIT_POR 1
`define IPS_BIT_BROWN 0
`define IPS_RCTL_WMASK 8'h93

// ************************************************
// bus answers
// ************************************************
`define IPS_RESP_OKAY 2'h0
`define IPS_RESP_SLVERR 2'h2

`endif

// *** rtl/ips_route.v ***
// Purpose: splits pending sources onto high and low request lines
// Assumes: inputs are from logic on the same clock
// Notes: registered outputs, one cycle of latency
`timescale 1ns/10ps
`include "ips_map.vh"

module ips_route (
	clk,
	rst,
	pending,
	level,
	prio_en,
	irq_high,
	irq_low
);
	input wire clk; // system clock
	input wire rst; // async reset, high
	input wire [`IPS_NSRC-1:0] pending; // enabled and flagged sources
	input wire [`IPS_NSRC-1:0] level; // 1 high, 0 low
	input wire prio_en; // two-level mode
	output reg irq_high; // high-priority request
	output reg irq_low; // low-priority request

	// ************************************************
	// per-source steering
	// ************************************************
	wire [`IPS_NSRC-1:0] to_high; // sources sent high
	wire [`IPS_NSRC-1:0] to_low; // sources sent low
	genvar g;
	generate
		for (g = 0; g < `IPS_NSRC; g = g + 1) begin : steer
			// compatibility mode sends all on the one line
			assign to_high[g] = pending[g] & (level[g] | ~prio_en);
			assign to_low[g] = pending[g] & ~level[g] & prio_en;
		end
	endgenerate

	// register the request lines
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_high <= 1'b0;
			irq_low <= 1'b0;
		end else begin
			irq_high <= |to_high;
			irq_low <= |to_low;
		end
	end
endmodule

// *** rtl/ips_top.v ***
// Purpose: interrupt priority select registers with axi4-lite slave
// Assumes: single clock, sources and events come from same-clock logic
// Notes: unmapped addresses answer slverr, reads give zero
`timescale 1ns/10ps
`include "ips_map.vh"

// Operation
// - priority register bits 7-5 read zero
// - bit 4 sets nvm write level
// - bit 3 sets bus collision level
// - bit 2 sets low voltage level
// - bit 1 sets timer three level
// - bit 0 sets capture compare two level
// - control bit 7 enables two levels
// - control bit 0 brown-out flag, resets zero
// - levels apply only when priority enabled
module ips_top (
	clk,
	rst,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	src_pending,
	swr_event,
	wdt_event,
	pwd_event,
	brown_out_event,
	irq_high,
	irq_low,
	prio_en_out
);
	input wire clk; // system clock
	input wire rst; // async reset, high
	input wire [`IPS_ADDR_W-1:0] s_axi_awaddr; // write address
	input wire s_axi_awvalid; // write address valid
	output reg s_axi_awready; // write address taken
	input wire [31:0] s_axi_wdata; // write data
	input wire [3:0] s_axi_wstrb; // byte enables
	input wire s_axi_wvalid; // write data valid
	output reg s_axi_wready; // write data taken
	output reg [1:0] s_axi_bresp; // write response
	output reg s_axi_bvalid; // write response valid
	input wire s_axi_bready; // master takes response
	input wire [`IPS_ADDR_W-1:0] s_axi_araddr; // read address
	input wire s_axi_arvalid; // read address valid
	output reg s_axi_arready; // read address taken
	output reg [31:0] s_axi_rdata; // read data
	output reg [1:0] s_axi_rresp; // read response
	output reg s_axi_rvalid; // read data valid
	input wire s_axi_rready; // master takes data
	input wire [`IPS_NSRC-1:0] src_pending; // enabled+flagged sources
	input wire swr_event; // software reset instruction pulse
	input wire wdt_event; // watchdog time-out pulse, clears flag
	input wire pwd_event; // sleep entry pulse, clears flag
	input wire brown_out_event; // brown-out pulse, clears flag
	output wire irq_high; // high-priority request
	output wire irq_low; // low-priority request
	output reg prio_en_out; // copy of priority enable

	// ************************************************
	// register state
	// ************************************************
	reg [`IPS_NSRC-1:0] level; // per-source priority bits
	reg prio_en; // two-level enable
	reg swr_flag; // software reset flag
	reg wdt_flag; // watchdog flag, read-only
	reg pwd_flag; // power-down flag, read-only
	reg por_flag; // power-on flag
	reg brown_out_reset_flag; // brown-out flag
	reg [`IPS_ADDR_W-1:0] aw_addr; // captured write address
	reg aw_held; // write address captured
	reg [7:0] w_data; // captured write byte
	reg w_en; // lane 0 strobe captured
	reg w_held; // write data captured

	// address decode used by both read and write paths
	function hit_prio;
		input [`IPS_ADDR_W-1:0] a;
		begin
			hit_prio = (a == `IPS_ADDR_PRIO2);
		end
	endfunction

	function hit_rctl;
		input [`IPS_ADDR_W-1:0] a;
		begin
			hit_rctl = (a == `IPS_ADDR_RCTL);
		end
	endfunction

	wire do_write; // both halves present, response free
	assign do_write = aw_held & w_held & ~s_axi_bvalid;
	wire wr_prio; // write hits priority register
	assign wr_prio = do_write & w_en & hit_prio(aw_addr);
	wire wr_rctl; // write hits control register
	assign wr_rctl = do_write & w_en & hit_rctl(aw_addr);

	// read views of the two registers
	wire [7:0] prio_view; // upper bits zero
	assign prio_view = {3'h0, level};
	wire [7:0] rctl_view; // bits 6-5 zero
	assign rctl_view = {prio_en, 2'h0, swr_flag, wdt_flag, pwd_flag,
		por_flag, brown_out_reset_flag};

	// ************************************************
	// write channel capture
	// ************************************************
	// address and data taken in either order
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held <= 1'b0;
			aw_addr <= 4'h0;
			w_held <= 1'b0;
			w_data <= 8'h00;
			w_en <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (do_write) begin
				aw_held <= 1'b0;
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata[7:0];
				w_en <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end else if (do_write) begin
				w_held <= 1'b0;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// write response
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IPS_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (hit_prio(aw_addr) | hit_rctl(aw_addr))
				s_axi_bresp <= `IPS_RESP_OKAY;
			else
				s_axi_bresp <= `IPS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ************************************************
	// registers
	// ************************************************
	// priority bits, all reset to high
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			level <= `IPS_PRIO2_RESET;
		end else if (wr_prio) begin
			level[`IPS_BIT_NVM] <= w_data[`IPS_BIT_NVM];
			level[`IPS_BIT_BCL] <= w_data[`IPS_BIT_BCL];
			level[`IPS_BIT_LVD] <= w_data[`IPS_BIT_LVD];
			level[`IPS_BIT_TMR3] <= w_data[`IPS_BIT_TMR3];
			level[`IPS_BIT_CCP2] <= w_data[`IPS_BIT_CCP2];
		end
	end

	// control and reset-cause flags; hardware events beat writes
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prio_en <= 1'b0;
			swr_flag <= 1'b1;
			wdt_flag <= 1'b1;
			pwd_flag <= 1'b1;
			por_flag <= 1'b0;
			brown_out_reset_flag <= 1'b0;
			prio_en_out <= 1'b0;
		end else begin
			if (wr_rctl)
				prio_en <= w_data[`IPS_BIT_PEN];
			prio_en_out <= wr_rctl ? w_data[`IPS_BIT_PEN] : prio_en;
			// reset instruction clears the flag
			if (swr_event)
				swr_flag <= 1'b0;
			else if (wr_rctl)
				swr_flag <= w_data[`IPS_BIT_SWR];
			// software cannot write these two
			if (wdt_event)
				wdt_flag <= 1'b0;
			if (pwd_event)
				pwd_flag <= 1'b0;
			if (wr_rctl)
				por_flag <= w_data[`IPS_BIT_POR];
			if (brown_out_event)
				brown_out_reset_flag <= 1'b0;
			else if (wr_rctl)
				brown_out_reset_flag <= w_data[`IPS_BIT_BROWN];
		end
	end

	// ************************************************
	// read channel
	// ************************************************
	// one read at a time, answer the cycle after the address
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `IPS_RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			if (hit_prio(s_axi_araddr)) begin
				s_axi_rdata <= {24'h000000, prio_view};
				s_axi_rresp <= `IPS_RESP_OKAY;
			end else if (hit_rctl(s_axi_araddr)) begin
				s_axi_rdata <= {24'h000000, rctl_view};
				s_axi_rresp <= `IPS_RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `IPS_RESP_SLVERR;
			end
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ************************************************
	// request routing
	// ************************************************
	ips_route u_route (
		.clk(clk),
		.rst(rst),
		.pending(src_pending),
		.level(level),
		.prio_en(prio_en),
		.irq_high(irq_high),
		.irq_low(irq_low)
	);
endmodule

// *** verif/ips_chk_sva.sv ***
// Purpose: port checks for the priority select block
// Assumes: one clock, reset high and asynchronous
// Notes: bound onto the top module
`timescale 1ns/10ps
`include "ips_map.vh"
module ips_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic s_axi_bvalid,
	input wire logic [`IPS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic [`IPS_NSRC-1:0] src_pending,
	input wire logic irq_high,
	input wire logic irq_low,
	input wire logic prio_en_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// address of the read now being answered
	logic [`IPS_ADDR_W-1:0] rd_addr;
	always @(posedge clk or posedge rst) begin
		if (rst)
			rd_addr <= 4'h0;
		else if (s_axi_arvalid && s_axi_arready)
			rd_addr <= s_axi_araddr;
	end
	// ************************************************
	// request routing and register bus
	// ************************************************
	a_any_route:
		assert property ((irq_high | irq_low) == |$past(src_pending))
		else $error("request lost");
	a_single_lvl:
		assert property (!$past(prio_en_out) |-> !irq_low
			&& irq_high == |$past(src_pending))
		else $error("single level misrouted");
	a_hl_excl:
		assert property ($past(prio_en_out) && $onehot($past(src_pending))
			|-> irq_high != irq_low)
		else $error("one source on both lines");
	a_pen_stable:
		assert property (!$rose(s_axi_bvalid) |-> $stable(prio_en_out))
		else $error("enable moved without write");
	a_rsv_zero:
		assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
			&& s_axi_rdata[6:5] == 2'h0)
		else $error("unused bits not zero");
	a_r_after:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_ar_busy:
		assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken during answer");
	a_err_zero:
		assert property (s_axi_rvalid && s_axi_rresp == 2'h2
			|-> s_axi_rdata == 32'h0)
		else $error("refused read not zero");
	a_prio_upper:
		assert property (s_axi_rvalid && rd_addr == `IPS_ADDR_PRIO2
			|-> s_axi_rdata[7:5] == 3'h0)
		else $error("priority upper bits not zero");
	c_both: cover property (irq_high && irq_low);
	c_low: cover property (irq_low);
	c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	c_pen: cover property ($rose(prio_en_out));
endmodule
bind ips_top ips_chk u_chk (.clk(clk), .rst(rst),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.src_pending(src_pending), .irq_high(irq_high), .irq_low(irq_low),
	.prio_en_out(prio_en_out));

// *** verif/ips_core_model.sv ***
// Purpose: core side that picks which vector to take
// Assumes: requests are registered levels
// Notes: high request preempts low
`timescale 1ns/10ps
module ips_core_model (
	input wire logic irq_high,
	input wire logic irq_low,
	output logic take_high,
	output logic take_low
);
	// ************************************************
	// vector choice
	// ************************************************
	assign take_high = irq_high;
	assign take_low = irq_low & ~irq_high;
endmodule

// *** verif/tb_interrupt_priority_select.sv ***
// Purpose: register and routing tests for the priority block
// Assumes: axi4-lite master, 100 MHz clock
// Notes: ready lines held high, both answers taken at once
`timescale 1ns/10ps
`include "ips_map.vh"
module tb_interrupt_priority_select;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic awv = 1'h0, wv = 1'h0, arv = 1'h0;
	logic [3:0] awa = 4'h0, ara = 4'h0, ev = 4'h0; // ev: swr wdt pwd brown
	logic [3:0] ws = 4'hf; // write strobes
	logic [31:0] wd = 32'h0;
	logic [4:0] pend = 5'h0;
	logic awr, wrd, bv, arr, rv, ih, il, pe, th, tl;
	logic [1:0] br, rr;
	logic [31:0] rdat;
	logic [7:0] e; // expected control value
	int errors = 0, checks_done = 0, i, j;
	always #5 clk = ~clk;
	ips_top u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'h1),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(1'h1), .src_pending(pend), .swr_event(ev[3]),
		.wdt_event(ev[2]), .pwd_event(ev[1]), .brown_out_event(ev[0]),
		.irq_high(ih), .irq_low(il), .prio_en_out(pe));
	ips_core_model u_core (.irq_high(ih), .irq_low(il), .take_high(th),
		.take_low(tl));
	// ************************************************
	// bus tasks
	// ************************************************
	task chk(input string nm, input [31:0] x, input [31:0] g);
		checks_done++;
		if (g !== x) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, x, g);
		end
	endtask
	task wr(input [3:0] a, input [31:0] d, input [1:0] er);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'h0;
			if (wv && wrd) wv <= 1'h0;
		end while (!bv);
		chk("bresp", er, br);
	endtask
	task rd(input [3:0] a, input [31:0] x, input [1:0] er);
		ara <= a;
		arv <= 1'h1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 1'h0;
		end while (!rv);
		chk("rdata", x, rdat);
		chk("rresp", er, rr);
	endtask
	task close_out;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ************************************************
	// tests
	// ************************************************
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		rd(`IPS_ADDR_PRIO2, 32'h1f, 2'h0);
		rd(`IPS_ADDR_RCTL, 32'h1c, 2'h0);
		wr(`IPS_ADDR_PRIO2, 32'hff, 2'h0);
		rd(`IPS_ADDR_PRIO2, 32'h1f, 2'h0);
		wr(`IPS_ADDR_RCTL, 32'h0, 2'h0);
		rd(`IPS_ADDR_RCTL, 32'h0c, 2'h0);
		// levels all low, yet one level mode sends all high
		wr(`IPS_ADDR_PRIO2, 32'h0, 2'h0);
		pend <= 5'h1f;
		repeat (2) @(posedge clk);
		chk("one level", 32'h2, {th, tl});
		chk("one level raw", 32'h2, {ih, il});
		wr(`IPS_ADDR_RCTL, 32'hff, 2'h0);
		chk("enable", 32'h1, pe);
		rd(`IPS_ADDR_RCTL, 32'h9f, 2'h0);
		// each level bit against each pending source
		for (i = 0; i < 5; i++) begin
			wr(`IPS_ADDR_PRIO2, 32'h1 << i, 2'h0);
			rd(`IPS_ADDR_PRIO2, 32'h1 << i, 2'h0);
			for (j = 0; j < 5; j++) begin
				pend <= 5'h1 << j;
				repeat (2) @(posedge clk);
				chk("route", (i == j) ? 32'h2 : 32'h1, {th, tl});
			end
			// every source pending: both lines up, core takes high
			pend <= 5'h1f;
			repeat (2) @(posedge clk);
			chk("both", 32'h3, {ih, il});
			chk("take", 32'h2, {th, tl});
		end
		// lane 0 strobe off: write ignored, level stays
		ws <= 4'he;
		wr(`IPS_ADDR_PRIO2, 32'h0, 2'h0);
		ws <= 4'hf;
		rd(`IPS_ADDR_PRIO2, 32'h10, 2'h0);
		// each event pulse clears its own flag only
		e = 8'h9f;
		for (i = 0; i < 4; i++) begin
			ev <= 4'h1 << i;
			@(posedge clk);
			ev <= 4'h0;
			@(posedge clk);
			e[(i == 0) ? 0 : i + 1] = 1'h0;
			rd(`IPS_ADDR_RCTL, {24'h0, e}, 2'h0);
		end
		wr(4'h8, 32'hff, `IPS_RESP_SLVERR);
		rd(4'h8, 32'h0, `IPS_RESP_SLVERR);
		close_out;
	end
	// hang guard, far beyond the test length
	initial begin
		#200000;
		errors++;
		close_out;
	end
endmodule
